// >>> crf_pkg.sv
package crf_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned PC_W   = 24;
  localparam int unsigned NUM_GP = 8;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h3
  } crf_size_t;

  typedef enum logic [2:0] {
    VW_LONG = 3'h0,
    VW_EXT  = 3'h1,
    VW_WORD = 3'h2,
    VW_HIGH = 3'h3,
    VW_LOW  = 3'h4
  } crf_view_t;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'h0,
    MD_MB1    = 2'h1,
    MD_ADV    = 2'h2
  } crf_mode_t;

  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_ADD  = 5'h01, OP_ADDX = 5'h02,
    OP_SUB  = 5'h03, OP_SUBX = 5'h04, OP_CMP  = 5'h05,
    OP_NEG  = 5'h06, OP_LOGIC = 5'h07, OP_SHL = 5'h08,
    OP_SHR  = 5'h09, OP_ROTL = 5'h0a, OP_ROTR = 5'h0b,
    OP_DAA  = 5'h0c, OP_DAS  = 5'h0d, OP_BLD  = 5'h0e,
    OP_BST  = 5'h0f, OP_BAND = 5'h10, OP_BOR  = 5'h11,
    OP_BXOR = 5'h12, OP_LDF  = 5'h13, OP_STF  = 5'h14,
    OP_ANDF = 5'h15, OP_ORF  = 5'h16, OP_XORF = 5'h17
  } crf_op_t;

  // flag byte layout
  localparam int unsigned FLAG_I  = 7;
  localparam int unsigned FLAG_UI = 6;
  localparam int unsigned FLAG_H  = 5;
  localparam int unsigned FLAG_U  = 4;
  localparam int unsigned FLAG_N  = 3;
  localparam int unsigned FLAG_Z  = 2;
  localparam int unsigned FLAG_V  = 1;
  localparam int unsigned FLAG_C  = 0;
  localparam logic [7:0]  FLAG_RST = 8'h80;

  localparam int unsigned BIT_INV = 3;
  localparam logic [2:0]  SP_IDX  = 3'h7;
  localparam logic [3:0]  LANE_ALL  = 4'hf;
  localparam logic [3:0]  LANE_EXT  = 4'hc;
  localparam logic [3:0]  LANE_WORD = 4'h3;
  localparam logic [3:0]  LANE_HIGH = 4'h2;
  localparam logic [3:0]  LANE_LOW  = 4'h1;

  localparam logic [4:0]  MSB_BYTE = 5'h07;
  localparam logic [4:0]  MSB_WORD = 5'h0f;
  localparam logic [4:0]  MSB_LONG = 5'h1f;
  localparam logic [5:0]  CY_BYTE  = 6'h08;
  localparam logic [5:0]  CY_WORD  = 6'h10;
  localparam logic [5:0]  CY_LONG  = 6'h20;
  localparam logic [5:0]  HC_BYTE  = 6'h04;
  localparam logic [5:0]  HC_WORD  = 6'h0c;
  localparam logic [5:0]  HC_LONG  = 6'h1c;
  localparam logic [31:0] MASK_BYTE  = 32'h000000ff;
  localparam logic [31:0] MASK_WORD  = 32'h0000ffff;
  localparam logic [31:0] MASK_LONG  = 32'hffffffff;
  localparam logic [31:0] HMASK_BYTE = 32'h0000000f;
  localparam logic [31:0] HMASK_WORD = 32'h00000fff;
  localparam logic [31:0] HMASK_LONG = 32'h0fffffff;

  localparam logic [7:0]  DA_HI_LIM = 8'h99;
  localparam logic [3:0]  DA_LO_LIM = 4'h9;
  localparam logic [7:0]  DA_HI_ADJ = 8'h60;
  localparam logic [7:0]  DA_LO_ADJ = 8'h06;

  localparam logic [23:0] PC_STEP    = 24'h000002;
  localparam logic [23:0] ADDR_M16   = 24'h00ffff;
  localparam logic [23:0] ADDR_M20   = 24'h0fffff;
  localparam logic [23:0] ADDR_M24   = 24'hffffff;
  localparam logic [23:0] ALIGN_EVEN = 24'hfffffe;
  localparam logic [31:0] SP_STEP_W  = 32'h00000002;
  localparam logic [31:0] SP_STEP_L  = 32'h00000004;

  // register add/subtract budget, longest time rounds down
  localparam int unsigned ADD_TIME_NS   = 80;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ADD_MAX_CYC   = ADD_TIME_NS / CLK_PERIOD_NS;

endpackage : crf_pkg

// >>> crf_gpr_if.sv
`timescale 1ns/1ns
interface crf_gpr_if;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [3:0]  wr_lane;
  logic [31:0] wr_data;
  logic [2:0]  rd_idx;
  wire  [31:0] rd_data;
  wire  [31:0] sp_data;

  modport bank (
    input  wr_en, wr_idx, wr_lane, wr_data, rd_idx,
    output rd_data, sp_data
  );
  modport core (
    output wr_en, wr_idx, wr_lane, wr_data, rd_idx,
    input  rd_data, sp_data
  );
endinterface : crf_gpr_if

// >>> crf_gpr_bank.sv
`timescale 1ns/1ns
module crf_gpr_bank
  import crf_pkg::*;
(
  input  wire logic clk_in,
  crf_gpr_if.bank   gif
);

  // one byte-wide array per lane so each view writes its lanes alone
  genvar ln;
  generate
    for (ln = 0; ln < 4; ln++)
    begin : g_lane
      logic [7:0] lane_q [0:NUM_GP-1];
      logic [7:0] rd_q;
      logic [7:0] sp_q;
      wire        hit = gif.wr_en && gif.wr_lane[ln];
      wire  [7:0] wbyte = gif.wr_data[8*ln +: 8];

      // no reset: contents stay undefined until software loads them
      always_ff @(posedge clk_in)
      begin
        if (hit)
          lane_q[gif.wr_idx] <= wbyte;
        rd_q <= lane_q[gif.rd_idx];
      end

      // stack view is write-through so back-to-back pushes chain
      always_ff @(posedge clk_in)
      begin
        if (hit && (gif.wr_idx == SP_IDX))
          sp_q <= wbyte;
        else
          sp_q <= lane_q[SP_IDX];
      end

      assign gif.rd_data[8*ln +: 8] = rd_q;
      assign gif.sp_data[8*ln +: 8] = sp_q;
    end
  endgenerate

endmodule : crf_gpr_bank

// >>> crf_core.sv
`timescale 1ns/1ns
// Functional notes
// - eight alike 32-bit general registers, usable for data or address.
// - each long register splits into extended and lower 16-bit halves.
// - lower half splits into upper and lower bytes, chosen per access.
// - eighth register doubles as stack pointer for calls and exceptions.
// - 24-bit program counter; fetch address always has bit 0 cleared.
// - mask bit 7 blocks interrupts except the non-maskable one.
// - every exception sequence start sets the mask bit.
// - bits 6 and 4 are user bits; bit 6 may also mask interrupts.
// - half carry from bit 3, 11 or 27 for byte, word, long.
// - negative flag copies the result sign bit.
// - zero flag set when result is zero, else cleared.
// - overflow flag set on arithmetic overflow, else cleared.
// - carry flag is add carry, subtract borrow, or shifted-out bit.
// - bit instructions use the carry flag as one-bit accumulator.
// - branches test N Z V C; some ops keep flags; flag ops exist.
// - reset clears PC to 0, sets mask and clears other flags; general registers left undefined.
// - normal mode limits to 64 kbytes, advanced mode reaches 16 Mbytes.
// - 1-Mbyte mode uses 20-bit addresses, dropping the top 4 bits.
// - bit ops pick bit 0 to 7 of a byte; decimal adjust packs BCD.
// - register add or subtract well inside its 20-cycle budget.
// - word and long addresses force bit 0 low without any error.
module crf_core
  import crf_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [1:0]  mode_pin_in,
  input  wire logic        irq_pin_in,
  input  wire logic        nmi_pin_in,
  input  wire logic        ui_mask_en_in,
  input  wire logic        gpr_wr_en_in,
  input  wire logic [2:0]  gpr_wr_idx_in,
  input  crf_view_t        gpr_wr_view_in,
  input  wire logic [31:0] gpr_wr_data_in,
  input  wire logic [2:0]  gpr_rd_idx_in,
  input  crf_view_t        gpr_rd_view_in,
  output logic      [31:0] gpr_rd_data_out,
  input  wire logic        sp_push_in,
  input  wire logic        sp_pop_in,
  input  wire logic        sp_long_in,
  output logic      [31:0] sp_out,
  input  wire logic        pc_vec_load_in,
  input  wire logic        pc_load_in,
  input  wire logic        pc_step_in,
  input  wire logic [23:0] pc_val_in,
  output logic      [23:0] fetch_addr_out,
  input  wire logic [23:0] ea_in,
  input  crf_size_t        ea_size_in,
  output logic      [23:0] ea_out,
  input  wire logic        op_valid_in,
  input  crf_op_t          op_in,
  input  crf_size_t        op_size_in,
  input  wire logic [31:0] opa_in,
  input  wire logic [31:0] opb_in,
  input  wire logic        exc_start_in,
  output logic      [31:0] result_out,
  output logic      [7:0]  flags_out,
  input  wire logic [3:0]  cond_in,
  output logic             cond_true_out,
  output logic             irq_accept_out
);

  crf_gpr_if gif ();

  crf_gpr_bank u_bank (
    .clk_in (clk_in),
    .gif    (gif)
  );

  // pin synchronisers
  logic [1:0] mode_s1_q, mode_s2_q;
  logic       irq_s1_q, irq_s2_q, nmi_s1_q, nmi_s2_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_s1_q <= MD_ADV;
      mode_s2_q <= MD_ADV;
      irq_s1_q  <= 1'b0;
      irq_s2_q  <= 1'b0;
      nmi_s1_q  <= 1'b0;
      nmi_s2_q  <= 1'b0;
    end
    else
    begin
      mode_s1_q <= mode_pin_in;
      mode_s2_q <= mode_s1_q;
      irq_s1_q  <= irq_pin_in;
      irq_s2_q  <= irq_s1_q;
      nmi_s1_q  <= nmi_pin_in;
      nmi_s2_q  <= nmi_s1_q;
    end
  end

  // general register views
  wire       sp_op = sp_push_in | sp_pop_in;
  wire [31:0] wr_ext  = {gpr_wr_data_in[15:0], 16'h0000};
  wire [31:0] wr_high = {16'h0000, gpr_wr_data_in[7:0], 8'h00};
  wire [3:0]  wlane =
    (gpr_wr_view_in == VW_LONG) ? LANE_ALL :
    (gpr_wr_view_in == VW_EXT)  ? LANE_EXT :
    (gpr_wr_view_in == VW_WORD) ? LANE_WORD :
    (gpr_wr_view_in == VW_HIGH) ? LANE_HIGH :
    (gpr_wr_view_in == VW_LOW)  ? LANE_LOW : 4'h0;
  wire [31:0] wdata = (gpr_wr_view_in == VW_EXT)  ? wr_ext :
                      (gpr_wr_view_in == VW_HIGH) ? wr_high :
                      gpr_wr_data_in;

  // stack adjust wins over a plain write in the same cycle
  wire [31:0] sp_amt  = sp_long_in ? SP_STEP_L : SP_STEP_W;
  wire [31:0] sp_next = sp_push_in ? gif.sp_data - sp_amt
                                   : gif.sp_data + sp_amt;
  assign gif.wr_en   = gpr_wr_en_in | sp_op;
  assign gif.wr_idx  = sp_op ? SP_IDX : gpr_wr_idx_in;
  assign gif.wr_lane = sp_op ? LANE_ALL : wlane;
  assign gif.wr_data = sp_op ? sp_next : wdata;
  assign gif.rd_idx  = gpr_rd_idx_in;

  crf_view_t   rd_view_q;
  wire [31:0] rd_view_d =
    (rd_view_q == VW_LONG) ? gif.rd_data :
    (rd_view_q == VW_EXT)  ? {16'h0000, gif.rd_data[31:16]} :
    (rd_view_q == VW_WORD) ? {16'h0000, gif.rd_data[15:0]} :
    (rd_view_q == VW_HIGH) ? {24'h000000, gif.rd_data[15:8]} :
    (rd_view_q == VW_LOW)  ? {24'h000000, gif.rd_data[7:0]} : 32'h00000000;

  // address clipping per mode
  logic [23:0] pc_q;
  wire [23:0] addr_mask = (mode_s2_q == MD_NORMAL) ? ADDR_M16 :
                          (mode_s2_q == MD_MB1)    ? ADDR_M20 :
                                                     ADDR_M24;
  wire [23:0] pc_d = (pc_vec_load_in | pc_load_in) ? pc_val_in :
                     pc_step_in ? pc_q + PC_STEP : pc_q;
  wire [23:0] ea_align = (ea_size_in == SZ_BYTE) ? ADDR_M24
                                                 : ALIGN_EVEN;

  // operand sizing
  wire is_b = (op_size_in == SZ_BYTE);
  wire is_w = (op_size_in == SZ_WORD);
  wire [4:0]  msb_idx = is_b ? MSB_BYTE : is_w ? MSB_WORD : MSB_LONG;
  wire [5:0]  cy_idx  = is_b ? CY_BYTE  : is_w ? CY_WORD  : CY_LONG;
  wire [5:0]  hc_idx  = is_b ? HC_BYTE  : is_w ? HC_WORD  : HC_LONG;
  wire [31:0] smask   = is_b ? MASK_BYTE : is_w ? MASK_WORD : MASK_LONG;
  wire [31:0] hmask   = is_b ? HMASK_BYTE : is_w ? HMASK_WORD : HMASK_LONG;
  wire [31:0] a_m = opa_in & smask;
  wire [31:0] b_m = opb_in & smask;

  logic [7:0] flags_q;
  wire is_sub = (op_in == OP_SUB) | (op_in == OP_SUBX) |
                (op_in == OP_CMP) | (op_in == OP_NEG);
  wire cin = ((op_in == OP_ADDX) | (op_in == OP_SUBX)) & flags_q[FLAG_C];
  wire [31:0] x_src = (op_in == OP_NEG) ? 32'h00000000 : a_m;
  wire [31:0] y_src = (op_in == OP_NEG) ? a_m : b_m;
  wire [32:0] sum_w = is_sub ? {1'b0, x_src} - {1'b0, y_src} - {32'h0, cin}
                             : {1'b0, x_src} + {1'b0, y_src} + {32'h0, cin};
  wire [32:0] hsum  = is_sub ? {1'b0, x_src & hmask} - {1'b0, y_src & hmask}
                               - {32'h0, cin}
                             : {1'b0, x_src & hmask} + {1'b0, y_src & hmask}
                               + {32'h0, cin};
  wire [31:0] ar_res = sum_w[31:0] & smask;
  wire xs = x_src[msb_idx];
  wire ys = y_src[msb_idx];
  wire rs = ar_res[msb_idx];
  wire ovf = is_sub ? ((xs != ys) && (rs != xs))
                    : ((xs == ys) && (rs != xs));

  // shifts and rotates by one place
  wire [31:0] shl_res  = (a_m << 1) & smask;
  wire [31:0] shr_res  = a_m >> 1;
  wire [31:0] rotl_res = ((a_m << 1) | {31'h0, a_m[msb_idx]}) & smask;
  wire [31:0] rotr_res = (a_m >> 1) | ({31'h0, a_m[0]} << msb_idx);

  // packed bcd correction on the low byte
  wire [7:0] abyte = opa_in[7:0];
  wire da_hi = flags_q[FLAG_C] | (abyte > DA_HI_LIM);
  wire da_lo = flags_q[FLAG_H] | (abyte[3:0] > DA_LO_LIM);
  wire [7:0] daa_cor = (da_hi ? DA_HI_ADJ : 8'h00) |
                       (da_lo ? DA_LO_ADJ : 8'h00);
  wire [7:0] das_cor = (flags_q[FLAG_C] ? DA_HI_ADJ : 8'h00) |
                       (flags_q[FLAG_H] ? DA_LO_ADJ : 8'h00);
  wire [7:0] daa_res = abyte + daa_cor;
  wire [7:0] das_res = abyte - das_cor;

  // bit n of a byte operand, bit 3 of the selector inverts it
  wire [2:0] bit_n = opb_in[2:0];
  wire       b_inv = opb_in[BIT_INV];
  wire       bit_v = abyte[bit_n] ^ b_inv;
  wire [7:0] bst_res = (abyte & ~(8'h01 << bit_n)) |
                       ({7'h00, flags_q[FLAG_C] ^ b_inv} << bit_n);

  logic [7:0]  flag_d;
  logic [31:0] res_d;

  always_comb
  begin
    flag_d = flags_q;
    res_d  = result_out;
    if (op_valid_in)
    begin
      case (op_in)
        OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG:
        begin
          res_d          = ar_res;
          flag_d[FLAG_H] = hsum[hc_idx];
          flag_d[FLAG_N] = rs;
          flag_d[FLAG_Z] = (ar_res == 32'h00000000);
          flag_d[FLAG_V] = ovf;
          flag_d[FLAG_C] = sum_w[cy_idx];
        end
        OP_LOGIC, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR:
        begin
          case (op_in)
            OP_SHL:  res_d = shl_res;
            OP_SHR:  res_d = shr_res;
            OP_ROTL: res_d = rotl_res;
            OP_ROTR: res_d = rotr_res;
            default: res_d = a_m;
          endcase
          flag_d[FLAG_N] = res_d[msb_idx];
          flag_d[FLAG_Z] = (res_d == 32'h00000000);
          flag_d[FLAG_V] = 1'b0;
          if (op_in == OP_SHL || op_in == OP_ROTL)
            flag_d[FLAG_C] = a_m[msb_idx];
          else if (op_in != OP_LOGIC)
            flag_d[FLAG_C] = a_m[0];
        end
        OP_DAA, OP_DAS:
        begin
          res_d = {24'h000000, (op_in == OP_DAA) ? daa_res : das_res};
          flag_d[FLAG_N] = res_d[MSB_BYTE];
          flag_d[FLAG_Z] = (res_d == 32'h00000000);
          if (op_in == OP_DAA)
            flag_d[FLAG_C] = da_hi;
        end
        OP_BLD:  flag_d[FLAG_C] = bit_v;
        OP_BAND: flag_d[FLAG_C] = flags_q[FLAG_C] & bit_v;
        OP_BOR:  flag_d[FLAG_C] = flags_q[FLAG_C] | bit_v;
        OP_BXOR: flag_d[FLAG_C] = flags_q[FLAG_C] ^ bit_v;
        OP_BST:  res_d = {24'h000000, bst_res};
        OP_LDF:  flag_d = opb_in[7:0];
        OP_ANDF: flag_d = flags_q & opb_in[7:0];
        OP_ORF:  flag_d = flags_q | opb_in[7:0];
        OP_XORF: flag_d = flags_q ^ opb_in[7:0];
        OP_STF:  res_d = {24'h000000, flags_q};
        default: flag_d = flags_q;
      endcase
    end
    // exception entry outranks any flag write in the same cycle
    if (exc_start_in)
      flag_d[FLAG_I] = 1'b1;
  end

  // branch conditions over N Z V C
  wire  f_n = flags_q[FLAG_N];
  wire  f_z = flags_q[FLAG_Z];
  wire  f_v = flags_q[FLAG_V];
  wire  f_c = flags_q[FLAG_C];
  // one bit per condition code, the code picks its own bit
  wire [15:0] cond_vec = {f_z | (f_n ^ f_v), ~(f_z | (f_n ^ f_v)),
                          f_n ^ f_v, ~(f_n ^ f_v), f_n, ~f_n, f_v, ~f_v,
                          f_z, ~f_z, f_c, ~f_c, f_c | f_z, ~(f_c | f_z),
                          1'b0, 1'b1};
  wire        cond_d   = cond_vec[cond_in];

  // user bit doubles as a second mask only when enabled
  wire irq_acc_d = nmi_s2_q |
                   (irq_s2_q & ~flags_q[FLAG_I] &
                    ~(ui_mask_en_in & flags_q[FLAG_UI]));

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_q        <= FLAG_RST;
      pc_q           <= 24'h000000;
      fetch_addr_out <= 24'h000000;
      ea_out         <= 24'h000000;
      result_out     <= 32'h00000000;
      cond_true_out  <= 1'b0;
      irq_accept_out <= 1'b0;
    end
    else
    begin
      flags_q        <= flag_d;
      pc_q           <= pc_d;
      fetch_addr_out <= pc_d & addr_mask & ALIGN_EVEN;
      ea_out         <= ea_in & addr_mask & ea_align;
      result_out     <= res_d;   // one cycle
      cond_true_out  <= cond_d;
      irq_accept_out <= irq_acc_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_view_q       <= VW_LONG;
      gpr_rd_data_out <= 32'h00000000;
      sp_out          <= 32'h00000000;
    end
    else
    begin
      rd_view_q       <= gpr_rd_view_in;
      gpr_rd_data_out <= rd_view_d;
      sp_out          <= gif.sp_data;
    end
  end

  assign flags_out = flags_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence exc_seq;
    exc_start_in ##1 flags_out[FLAG_I];
  endsequence

  wire arith_op = op_valid_in && !exc_start_in &&
                  (op_in inside {OP_ADD, OP_ADDX, OP_SUB,
                                 OP_SUBX, OP_CMP, OP_NEG});

  exc_mask_set_a: assert property (exc_start_in |-> exc_seq)
    else $error("mask bit not set on exception entry");
  irq_gate_a: assert property (
    irq_accept_out && !$past(nmi_s2_q) |-> !$past(flags_q[FLAG_I]))
    else $error("interrupt accepted while masked");
  nmi_pass_a: assert property (nmi_s2_q |=> irq_accept_out)
    else $error("nmi not accepted");
  fetch_even_a: assert property (
    pc_step_in && !pc_load_in && !pc_vec_load_in |=>
      pc_q == $past(pc_q) + PC_STEP && !fetch_addr_out[0])
    else $error("pc step or fetch alignment wrong");
  zero_flag_a: assert property (
    arith_op |=> flags_out[FLAG_Z] == (result_out == 32'h00000000))
    else $error("zero flag disagrees with result");
  add_carry_a: assert property (
    arith_op && op_in == OP_ADD && op_size_in == SZ_BYTE |=>
      flags_out[FLAG_C] == (({1'b0, $past(opa_in[7:0])} +
                             {1'b0, $past(opb_in[7:0])}) > 9'h0ff))
    else $error("byte add carry wrong");
  half_borrow_a: assert property (
    arith_op && op_in == OP_SUB && op_size_in == SZ_WORD |=>
      flags_out[FLAG_H] == ($past(opa_in[11:0]) < $past(opb_in[11:0])))
    else $error("word subtract half borrow wrong");
  user_bits_a: assert property (
    op_valid_in && op_in == OP_LDF && !exc_start_in |=>
      flags_out[FLAG_UI] == $past(opb_in[FLAG_UI]) &&
      flags_out[FLAG_U] == $past(opb_in[FLAG_U]))
    else $error("user bits not loaded");
  bit_load_a: assert property (
    op_valid_in && op_in == OP_BLD |=>
      flags_out[FLAG_C] == ($past(opa_in[opb_in[2:0]]) ^
                            $past(opb_in[BIT_INV])))
    else $error("bit load into carry wrong");
  normal_mode_a: assert property (
    mode_s2_q == MD_NORMAL |=> ea_out[23:16] == 8'h00)
    else $error("normal mode address above 64 kbytes");
  stack_push_a: assert property (
    sp_push_in && !sp_pop_in && sp_long_in |->
      ##2 sp_out == $past(gif.sp_data, 2) - SP_STEP_L)
    else $error("long push did not drop stack by four");

endmodule : crf_core

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import crf_pkg::*;
  logic        clk_in = 0, rst_n_in = 0;
  logic [1:0]  mode_pin_in = 2'h2;
  logic        irq_pin_in = 0, nmi_pin_in = 0, ui_mask_en_in = 0;
  logic        gpr_wr_en_in = 0, sp_push_in = 0, sp_pop_in = 0;
  logic        sp_long_in = 0, pc_vec_load_in = 0, pc_load_in = 0;
  logic        pc_step_in = 0, op_valid_in = 0, exc_start_in = 0;
  logic [2:0]  gpr_wr_idx_in = 3'h0, gpr_rd_idx_in = 3'h0;
  crf_view_t   gpr_wr_view_in = VW_LONG, gpr_rd_view_in = VW_LONG;
  logic [31:0] gpr_wr_data_in = 32'h0, opa_in = 32'h0, opb_in = 32'h0;
  logic [23:0] pc_val_in = 24'h0, ea_in = 24'h0;
  crf_size_t   ea_size_in = SZ_BYTE, op_size_in = SZ_BYTE;
  crf_op_t     op_in = OP_NOP;
  logic [3:0]  cond_in = 4'h0;
  logic [31:0] gpr_rd_data_out, sp_out, result_out;
  logic [23:0] fetch_addr_out, ea_out;
  logic [7:0]  flags_out;
  logic        cond_true_out, irq_accept_out;
  int          n_errors = 0, samples_checked = 0;

  crf_core dut_u (.*);

  always #2 clk_in = ~clk_in;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task close_out();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task wr(input logic [2:0] i, input crf_view_t v, input logic [31:0] d);
    @(posedge clk_in);
    gpr_wr_en_in <= 1; gpr_wr_idx_in <= i; gpr_wr_view_in <= v;
    gpr_wr_data_in <= d;
    @(posedge clk_in);
    gpr_wr_en_in <= 0;
  endtask : wr

  task rd(input logic [2:0] i, input crf_view_t v, input logic [31:0] e);
    @(posedge clk_in);
    gpr_rd_idx_in <= i; gpr_rd_view_in <= v;
    repeat (3) @(posedge clk_in);
    #1 chk(gpr_rd_data_out, e);
  endtask : rd

  task sp(input logic push, input logic lng, input logic [31:0] e);
    @(posedge clk_in);
    sp_push_in <= push; sp_pop_in <= !push; sp_long_in <= lng;
    @(posedge clk_in);
    sp_push_in <= 0; sp_pop_in <= 0;
    repeat (2) @(posedge clk_in);
    #1 chk(sp_out, e);
  endtask : sp

  // one-cycle op; outputs land on the taking edge
  task run_op(input crf_op_t o, input crf_size_t s,
              input logic [31:0] a, input logic [31:0] b,
              input logic [31:0] er, input logic [7:0] ef);
    @(posedge clk_in);
    op_valid_in <= 1; op_in <= o; op_size_in <= s; opa_in <= a; opb_in <= b;
    @(posedge clk_in);
    op_valid_in <= 0;
    #1 chk(flags_out, ef);
    if (o != OP_LDF && o != OP_BLD) chk(result_out, er);
  endtask : run_op

  // waits, then leaves the caller just past the edge to sample outputs
  task settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  initial
  begin
    #20000;
    n_errors++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    #1 chk(flags_out, 8'h80);
    wr(7, VW_LONG, 32'h00001000);
    for (int k = 0; k < 7; k++) wr(k[2:0], VW_LONG, 32'h01010101 * k);
    for (int k = 0; k < 7; k++) rd(k[2:0], VW_LONG, 32'h01010101 * k);
    wr(2, VW_LOW, 32'h5a); wr(2, VW_EXT, 32'hbeef); wr(2, VW_HIGH, 32'h77);
    rd(2, VW_LONG, 32'hbeef775a);
    rd(2, VW_HIGH, 32'h77);
    rd(2, VW_EXT, 32'hbeef);
    rd(2, VW_WORD, 32'h775a);
    rd(2, VW_LOW, 32'h5a);
    $display("test registers done");
    sp(1, 1, 32'h00000ffc);
    sp(1, 0, 32'h00000ffa);
    sp(0, 1, 32'h00000ffe);
    $display("test stack done");
    @(posedge clk_in);
    pc_vec_load_in <= 1; pc_val_in <= 24'h001235;
    @(posedge clk_in);
    pc_vec_load_in <= 0; pc_step_in <= 1;
    #1 chk(fetch_addr_out, 24'h001234);
    @(posedge clk_in);
    pc_step_in <= 0;
    #1 chk(fetch_addr_out, 24'h001236);
    $display("test pc done");
    run_op(OP_ADD, SZ_BYTE, 32'hff, 32'h01, 32'h0, 8'ha5);
    run_op(OP_ADD, SZ_WORD, 32'h0fff, 32'h1, 32'h1000, 8'ha0);
    run_op(OP_ADD, SZ_LONG, 32'h7fffffff, 32'h1, 32'h80000000, 8'haa);
    run_op(OP_SUB, SZ_BYTE, 32'h0, 32'h1, 32'hff, 8'ha9);
    run_op(OP_LDF, SZ_BYTE, 32'h0, 32'h50, 32'h0, 8'h50);
    run_op(OP_BLD, SZ_BYTE, 32'h08, 32'h03, 32'h0, 8'h51);
    @(posedge clk_in);
    exc_start_in <= 1; cond_in <= 4'h6; irq_pin_in <= 1;
    @(posedge clk_in);
    exc_start_in <= 0;
    #1 chk(flags_out, 8'hd1);
    settle(4);
    chk(cond_true_out, 1'b1);
    chk(irq_accept_out, 1'b0);
    @(posedge clk_in);
    nmi_pin_in <= 1;
    settle(4);
    chk(irq_accept_out, 1'b1);
    $display("test flags done");
    @(posedge clk_in);
    mode_pin_in <= 2'h1; ea_in <= 24'h123457; ea_size_in <= SZ_WORD;
    settle(4);
    chk(ea_out, 24'h023456);
    @(posedge clk_in);
    mode_pin_in <= 2'h0; ea_size_in <= SZ_BYTE;
    settle(4);
    chk(ea_out, 24'h003457);
    $display("test address done");
    @(posedge clk_in);
    rst_n_in <= 0;
    @(posedge clk_in);
    rst_n_in <= 1;
    #1 chk(flags_out, 8'h80);
    $display("test reset done");
    close_out();
  end
endmodule : tb_top
